// *** verilog/acr_top.sv ***
/*
  Control, status and result registers of a 10-bit successive
  approximation converter, with trigger selection, prescaler and
  digital input buffer disables.
  Assumes a synchronous register port, pin inputs synchronous to
  I_MCLK, and an analog core whose result is valid at completion.
*/
// Operation
// - Single mode: each start write converts once
// - Free run: start write launches first conversion
// - First conversion 25 clocks, later 13
// - Start bit reads busy; zero write ignored
// - Auto trigger starts on selected rising edge
// - Done flag set after result update
// - Interrupt when flag, enable, global enable set
// - Flag cleared by vector or one write
// - Divider code selects 2 to 128
// - Left adjust moves result between bytes
// - Differential channels give two's complement
// - Low read locks result until high read
// - High speed bit selects fast mode
// - Extension bit is channel code MSB
// - Trigger source ignored without auto trigger
// - Switching to set source is an edge
// - Switching to free running never triggers
// - Trigger code decode table
// - Disable bits gate pin buffers to zero
// - Enable powers converter; clearing aborts
`timescale 1ns/1ps
`include "acr_cfg.svh"

module acr_top (
  // Clock, reset, enable
  input  wire logic             I_MCLK,
  input  wire logic             I_RST_N,
  input  wire logic             I_CE,
  // Register port
  input  wire acr_pkg::acr_addr_t I_ADDR,
  input  wire acr_pkg::acr_byte_t I_WDATA,
  input  wire logic             I_WR,
  input  wire logic             I_RD,
  output      acr_pkg::acr_byte_t O_RDATA,
  // Processor side
  input  wire logic             I_GIE,
  input  wire logic             I_IRQ_ACK,
  output      logic             O_IRQ,
  // Trigger sources, bit n is code n+1
  input  wire logic [10:0]      I_TRIG,
  // Analog core
  input  wire acr_pkg::acr_res_t  I_CORE_RESULT,
  output      logic             O_CORE_EN,
  output      logic             O_CORE_START,
  output      logic             O_CORE_INIT,
  output      logic             O_CORE_TICK,
  output      logic             O_HIGH_SPEED,
  output      logic             O_COMP_MUX_EN,
  output      acr_pkg::acr_chan_t O_CHANNEL,
  output      logic [1:0]       O_REF_SEL,
  output      logic             O_BUSY,
  // Pin buffers
  input  wire logic [7:0]       I_PIN_LOW,
  input  wire logic [5:0]       I_PIN_HIGH,
  output      logic [7:0]       O_PIN_LOW,
  output      logic [5:0]       O_PIN_HIGH,
  output      logic [7:0]       O_BUF_OFF_LOW,
  output      logic [5:0]       O_BUF_OFF_HIGH
);
  import acr_pkg::*;

  function automatic logic hit(input acr_addr_t a, input acr_addr_t off);
    hit = (a == off);
  endfunction

  // Terminal count of the prescaler for a divider code
  function automatic logic [6:0] div_tc(input logic [2:0] code);
    case (code)
      3'h0:    div_tc = 7'h01;
      3'h1:    div_tc = 7'h01;
      3'h2:    div_tc = 7'h03;
      3'h3:    div_tc = 7'h07;
      3'h4:    div_tc = 7'h0F;
      3'h5:    div_tc = 7'h1F;
      3'h6:    div_tc = 7'h3F;
      default: div_tc = 7'h7F;
    endcase
  endfunction

  // Register state
  logic       enable;
  logic       auto_trig;
  logic       done_flag;
  logic       irq_en;
  logic [2:0] clock_divider_select;
  logic       high_speed_select;
  logic       comparator_mux_enable;
  logic       channel_select_msb;
  logic [3:0] trigger_source_select;
  logic       left_adjust_select;
  logic [4:0] chan_low;
  logic [1:0] ref_sel;
  logic [7:0] did_low;
  logic [5:0] did_high;
  acr_res_t   result;
  logic       res_lock;

  // Conversion state
  acr_state_t state;
  logic       first_pend;
  logic       conv_first;
  logic [6:0] pre_cnt;
  logic [4:0] cyc_cnt;
  logic       trig_prev;

  // Bus decode
  wire wr_csra = I_WR & hit(I_ADDR, `ACR_OFF_CSRA);
  wire wr_csrb = I_WR & hit(I_ADDR, `ACR_OFF_CSRB);
  wire wr_mux  = I_WR & hit(I_ADDR, `ACR_OFF_MUX);
  wire wr_didl = I_WR & hit(I_ADDR, `ACR_OFF_DIDL);
  wire wr_didh = I_WR & hit(I_ADDR, `ACR_OFF_DIDH);
  wire rd_resl = I_RD & hit(I_ADDR, `ACR_OFF_RESL);
  wire rd_resh = I_RD & hit(I_ADDR, `ACR_OFF_RESH);

  wire busy   = (state == ACR_CONV);
  wire en_new = I_WDATA[`ACR_A_EN];

  // Enabling in this write still counts as first conversion
  wire en_rise = wr_csra & en_new & ~enable;
  wire abort   = wr_csra & ~en_new;

  // Only a written one starts; a zero leaves the bit alone
  wire sw_start = wr_csra & en_new & I_WDATA[`ACR_A_START];

  // Trigger selection; code 0 and unused codes give a low level
  wire ts_valid = (trigger_source_select != `ACR_TS_FREE) &
                  (trigger_source_select <= `ACR_TS_LAST);
  wire [3:0] ts_idx = trigger_source_select - 4'h1;
  wire trig_sel = ts_valid & I_TRIG[ts_idx];

  // Previous selected level, so switching sources can make an edge
  wire trig_edge = trig_sel & ~trig_prev;
  wire hw_start  = enable & auto_trig & trig_edge;
  wire free_run  = auto_trig & (trigger_source_select == `ACR_TS_FREE);

  // Converter clock and cycle counting
  wire [6:0] tc     = div_tc(clock_divider_select);
  wire       tick   = busy & (pre_cnt == tc);
  wire [4:0] len    = conv_first ? `ACR_CYC_FIRST : `ACR_CYC_NORM;
  wire       finish = tick & (cyc_cnt == len - 5'd1);

  // Differential codes flip offset binary into two's complement
  acr_chan_t chan;
  assign chan = {channel_select_msb, chan_low};
  wire is_diff = chan[4] | chan[3];
  wire [9:0] core_val = is_diff ? (I_CORE_RESULT ^ `ACR_DIFF_FLIP)
                                : I_CORE_RESULT;

  // Results are held while software is between low and high reads
  wire capture = finish & ~res_lock & ~abort;

  wire idle_start = ~busy & enable & (sw_start | hw_start);
  wire en_start   = ~busy & ~enable & sw_start;
  wire fr_restart = finish & free_run & enable & ~abort;
  wire go         = (idle_start | en_start | fr_restart) & ~abort;

  // Next-state decode
  acr_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      ACR_IDLE: begin
        if (go)
          next_state = ACR_CONV;
      end
      ACR_CONV: begin
        if (abort)
          next_state = ACR_IDLE;
        else if (finish & ~fr_restart)
          next_state = ACR_IDLE;
      end
      default: next_state = ACR_IDLE;
    endcase
  end

  // Read mux, layout follows left adjust
  wire [7:0] res_lo = left_adjust_select ? {result[1:0], 6'h00}
                                         : result[7:0];
  wire [7:0] res_hi = left_adjust_select ? result[9:2]
                                         : {6'h00, result[9:8]};
  wire [7:0] csra_rd = {enable, busy, auto_trig, done_flag, irq_en,
                        clock_divider_select};
  wire [7:0] csrb_rd = {high_speed_select, comparator_mux_enable,
                        channel_select_msb, 1'b0, trigger_source_select};
  wire [7:0] mux_rd  = {ref_sel, left_adjust_select, chan_low};

  acr_byte_t next_rdata;
  always_comb begin
    next_rdata = `ACR_RST_BYTE;
    if (I_RD) begin
      case (I_ADDR)
        `ACR_OFF_CSRA: next_rdata = csra_rd;
        `ACR_OFF_RESL: next_rdata = res_lo;
        `ACR_OFF_RESH: next_rdata = res_hi;
        `ACR_OFF_CSRB: next_rdata = csrb_rd;
        `ACR_OFF_MUX:  next_rdata = mux_rd;
        `ACR_OFF_DIDL: next_rdata = did_low;
        `ACR_OFF_DIDH: next_rdata = {2'b00, did_high};
        default:       next_rdata = `ACR_RST_BYTE;
      endcase
    end
  end

  // Flag: a completion in the clearing cycle wins
  wire flag_clr   = (wr_csra & I_WDATA[`ACR_A_FLAG]) | I_IRQ_ACK;
  wire next_flag  = capture | (done_flag & ~flag_clr);
  wire next_irq   = next_flag & irq_en & I_GIE;

  // Control registers
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      enable                <= 1'b0;
      auto_trig             <= 1'b0;
      irq_en                <= 1'b0;
      clock_divider_select  <= 3'h0;
    end else if (I_CE && wr_csra) begin
      enable                <= en_new;
      auto_trig             <= I_WDATA[`ACR_A_ATE];
      irq_en                <= I_WDATA[`ACR_A_IE];
      clock_divider_select  <= I_WDATA[2:0];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      high_speed_select     <= 1'b0;
      comparator_mux_enable <= 1'b0;
      channel_select_msb    <= 1'b0;
      trigger_source_select <= 4'h0;
    end else if (I_CE && wr_csrb) begin
      high_speed_select     <= I_WDATA[`ACR_B_HSM];
      comparator_mux_enable <= I_WDATA[`ACR_B_CME];
      channel_select_msb    <= I_WDATA[`ACR_B_MSB];
      trigger_source_select <= I_WDATA[3:0];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ref_sel               <= 2'h0;
      left_adjust_select    <= 1'b0;
      chan_low              <= 5'h00;
    end else if (I_CE && wr_mux) begin
      ref_sel               <= I_WDATA[7:6];
      left_adjust_select    <= I_WDATA[`ACR_M_LAR];
      chan_low              <= I_WDATA[4:0];
    end
  end

  // Only documented disable bits are writable
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      did_low  <= `ACR_RST_BYTE;
      did_high <= 6'h00;
    end else if (I_CE) begin
      if (wr_didl)
        did_low <= I_WDATA & `ACR_DIDL_MASK;
      if (wr_didh)
        did_high <= I_WDATA[5:0] & `ACR_DIDH_MASK;
    end
  end

  // Result, lock and flag
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      result    <= `ACR_RST_RES;
      res_lock  <= 1'b0;
      done_flag <= 1'b0;
    end else if (I_CE) begin
      if (capture)
        result <= core_val;
      if (rd_resl)
        res_lock <= 1'b1;
      else if (rd_resh)
        res_lock <= 1'b0;
      done_flag <= next_flag;
    end
  end

  // Conversion sequencing
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state      <= ACR_IDLE;
      first_pend <= 1'b0;
      conv_first <= 1'b0;
    end else if (I_CE) begin
      state <= next_state;
      if (go) begin
        conv_first <= first_pend | en_rise;
        first_pend <= 1'b0;
      end else if (en_rise)
        first_pend <= 1'b1;
    end
  end

  // Prescaler restarts with each conversion for exact length
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pre_cnt <= 7'h00;
      cyc_cnt <= 5'h00;
    end else if (I_CE) begin
      if (go || !busy) begin
        pre_cnt <= 7'h00;
        cyc_cnt <= 5'h00;
      end else if (tick) begin
        pre_cnt <= 7'h00;
        cyc_cnt <= cyc_cnt + 5'd1;
      end else
        pre_cnt <= pre_cnt + 7'd1;
    end
  end

  // Edge history tracks the selected level even when not armed
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N)
      trig_prev <= 1'b0;
    else if (I_CE)
      trig_prev <= trig_sel;
  end

  // Registered outputs
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA        <= `ACR_RST_BYTE;
      O_IRQ          <= 1'b0;
      O_CORE_EN      <= 1'b0;
      O_CORE_START   <= 1'b0;
      O_CORE_INIT    <= 1'b0;
      O_CORE_TICK    <= 1'b0;
      O_HIGH_SPEED   <= 1'b0;
      O_COMP_MUX_EN  <= 1'b0;
      O_CHANNEL      <= 6'h00;
      O_REF_SEL      <= 2'h0;
      O_BUSY         <= 1'b0;
    end else if (I_CE) begin
      O_RDATA        <= next_rdata;
      O_IRQ          <= next_irq;
      O_CORE_EN      <= wr_csra ? en_new : enable;
      O_CORE_START   <= go;
      // Drops with busy so init never outlives the conversion
      O_CORE_INIT    <= (next_state == ACR_CONV) &
                        (go ? (first_pend | en_rise) : conv_first);
      O_CORE_TICK    <= tick & ~abort;
      O_HIGH_SPEED   <= high_speed_select;
      O_COMP_MUX_EN  <= comparator_mux_enable;
      O_CHANNEL      <= chan;
      O_REF_SEL      <= ref_sel;
      O_BUSY         <= (next_state == ACR_CONV);
    end
  end

  // Pin buffers off and pin reads forced low
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PIN_LOW      <= 8'h00;
      O_PIN_HIGH     <= 6'h00;
      O_BUF_OFF_LOW  <= 8'h00;
      O_BUF_OFF_HIGH <= 6'h00;
    end else if (I_CE) begin
      O_PIN_LOW      <= I_PIN_LOW & ~did_low;
      O_PIN_HIGH     <= I_PIN_HIGH & ~did_high;
      O_BUF_OFF_LOW  <= did_low;
      O_BUF_OFF_HIGH <= did_high;
    end
  end

endmodule

// *** verilog/acr_cfg.svh ***
/*
  Register offsets, field positions, reset values and timing counts
  of the converter control block. Assumes inclusion by bare name.
*/
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

`define ACR_OFF_CSRA   4'h0
`define ACR_OFF_RESL   4'h1
`define ACR_OFF_RESH   4'h2
`define ACR_OFF_CSRB   4'h3
`define ACR_OFF_MUX    4'h4
`define ACR_OFF_DIDL   4'h5
`define ACR_OFF_DIDH   4'h6

`define ACR_A_EN       7
`define ACR_A_START    6
`define ACR_A_ATE      5
`define ACR_A_FLAG     4
`define ACR_A_IE       3
`define ACR_B_HSM      7
`define ACR_B_CME      6
`define ACR_B_MSB      5
`define ACR_M_LAR      5

`define ACR_RST_BYTE   8'h00
`define ACR_RST_RES    10'h000
`define ACR_DIDL_MASK  8'hF3
`define ACR_DIDH_MASK  6'h3F
`define ACR_DIFF_FLIP  10'h200

`define ACR_TS_FREE    4'h0
`define ACR_TS_LAST    4'hB

`define ACR_CYC_FIRST  5'd25
`define ACR_CYC_NORM   5'd13

`endif

// *** verilog/acr_pkg.sv ***
/*
  Types shared by the converter control block.
  Assumes the constants header is compiled alongside.
*/
package acr_pkg;

  typedef logic [7:0] acr_byte_t;
  typedef logic [3:0] acr_addr_t;
  typedef logic [9:0] acr_res_t;
  typedef logic [5:0] acr_chan_t;

  typedef enum logic [0:0] {
    ACR_IDLE,
    ACR_CONV
  } acr_state_t;

endpackage

// *** verif/acr_core_model.sv ***
/*
  Behavioural model of the analog conversion core.
  Assumes start and busy come straight from the control block.
*/
`timescale 1ns/1ps
module acr_core_model (
  // Clock and control from the block
  input  wire logic             i_clk,
  input  wire logic             i_start,
  input  wire logic             i_busy,
  // Next value to convert, set by the bench
  input  wire acr_pkg::acr_res_t i_value,
  // Result towards the block
  output      acr_pkg::acr_res_t o_result
);
  import acr_pkg::*;

  acr_res_t held = 10'h155;

  // Value captured when the core is started
  always @(posedge i_clk) begin
    if (i_start) begin
      held <= i_value;
    end
  end

  // Stable through completion; inverted once idle so a late sample shows
  assign o_result = i_busy ? held : ~held;
endmodule

// *** verif/acr_assertions.sv ***
/*
  Concurrent checks on the converter control block ports.
  Assumes binding to acr_top with one clock and active-low reset.
*/
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_assertions (
  // Clock and reset
  input  wire logic             I_MCLK,
  input  wire logic             I_RST_N,
  // Register port and processor
  input  wire logic             I_CE,
  input  wire acr_pkg::acr_addr_t I_ADDR,
  input  wire acr_pkg::acr_byte_t I_WDATA,
  input  wire logic             I_WR,
  input  wire logic             I_GIE,
  // Watched outputs
  input  wire logic             O_IRQ,
  input  wire logic             O_CORE_EN,
  input  wire logic             O_CORE_START,
  input  wire logic             O_CORE_INIT,
  input  wire logic             O_CORE_TICK,
  input  wire logic             O_HIGH_SPEED,
  input  wire acr_pkg::acr_chan_t O_CHANNEL,
  input  wire logic             O_BUSY,
  input  wire logic [7:0]       O_PIN_LOW,
  input  wire logic [5:0]       O_PIN_HIGH,
  input  wire logic [7:0]       O_BUF_OFF_LOW,
  input  wire logic [5:0]       O_BUF_OFF_HIGH
);
  import acr_pkg::*;

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);

  a_irq_gie: assert property ($past(I_CE) && O_IRQ |-> $past(I_GIE))
    else $error("interrupt raised without global enable");
  a_start_busy: assert property (O_CORE_START |-> O_BUSY)
    else $error("core start outside busy");
  a_busy_start: assert property ($rose(O_BUSY) |-> O_CORE_START)
    else $error("busy rose without core start");
  a_busy_en: assert property (O_BUSY |-> O_CORE_EN)
    else $error("busy while converter off");
  a_init_busy: assert property (O_CORE_INIT |-> O_BUSY)
    else $error("init outside conversion");
  // Gate and disable launch from one register, so they never disagree
  a_pin_low_gate: assert property ((O_PIN_LOW & O_BUF_OFF_LOW) == 8'h00)
    else $error("disabled low pin reads one");
  a_pin_high_gate: assert property ((O_PIN_HIGH & O_BUF_OFF_HIGH) == 6'h00)
    else $error("disabled high pin reads one");
  a_tick_busy: assert property (O_CORE_TICK |-> $past(O_BUSY))
    else $error("converter tick outside conversion");
  // Register then output flop: the written value shows two cycles on
  a_hsm_write: assert property (I_CE && I_WR && I_ADDR == `ACR_OFF_CSRB
    |-> ##2 O_HIGH_SPEED == $past(I_WDATA[`ACR_B_HSM], 2))
    else $error("high speed bit not applied");
  a_msb_write: assert property (I_CE && I_WR && I_ADDR == `ACR_OFF_CSRB
    |-> ##2 O_CHANNEL[5] == $past(I_WDATA[`ACR_B_MSB], 2))
    else $error("channel msb not applied");
  a_chan_write: assert property (I_CE && I_WR && I_ADDR == `ACR_OFF_MUX
    |-> ##2 O_CHANNEL[4:0] == $past(I_WDATA[4:0], 2))
    else $error("channel code not applied");
endmodule

bind acr_top acr_assertions u_acr_assertions (
  .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_GIE(I_GIE), .O_IRQ(O_IRQ),
  .O_CORE_EN(O_CORE_EN), .O_CORE_START(O_CORE_START), .O_CORE_INIT(O_CORE_INIT),
  .O_CORE_TICK(O_CORE_TICK),
  .O_HIGH_SPEED(O_HIGH_SPEED), .O_CHANNEL(O_CHANNEL), .O_BUSY(O_BUSY),
  .O_PIN_LOW(O_PIN_LOW), .O_PIN_HIGH(O_PIN_HIGH),
  .O_BUF_OFF_LOW(O_BUF_OFF_LOW), .O_BUF_OFF_HIGH(O_BUF_OFF_HIGH)
);

// *** verif/tb.sv ***
/*
  Self-checking bench for the converter control block.
  Assumes the design, the core model and the checker compiled first.
*/
`timescale 1ns/1ps
module tb;
  import acr_pkg::*;

  logic        clk, rst_n, wr, rd, rd_d, gie, ack, cen, cst, busy, irq, hs, cme;
  logic [1:0]  rsel;
  acr_addr_t   addr;
  acr_byte_t   wdata, rdata;
  acr_res_t    res, nv, r;
  acr_chan_t   chan;
  logic [10:0] trig;
  logic [7:0]  pl, opl;
  logic [5:0]  ph, oph;
  acr_byte_t   eq[$];
  string       nq[$];
  int          fail_count, total_checks, cyc, n;

  acr_top u_acr_top (
    .I_MCLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_GIE(gie), .I_IRQ_ACK(ack), .O_IRQ(irq),
    .I_TRIG(trig), .I_CORE_RESULT(res), .O_CORE_EN(cen), .O_CORE_START(cst),
    .O_CORE_INIT(), .O_CORE_TICK(), .O_HIGH_SPEED(hs), .O_COMP_MUX_EN(cme),
    .O_CHANNEL(chan), .O_REF_SEL(rsel), .O_BUSY(busy), .I_PIN_LOW(pl), .I_PIN_HIGH(ph),
    .O_PIN_LOW(opl), .O_PIN_HIGH(oph), .O_BUF_OFF_LOW(), .O_BUF_OFF_HIGH()
  );

  acr_core_model u_acr_core_model (
    .i_clk(clk), .i_start(cst), .i_busy(busy), .i_value(nv), .o_result(res)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wreg(input acr_addr_t a, input acr_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Expected read data is queued; the monitor below compares it
  task automatic rreg(input acr_addr_t a, input acr_byte_t e, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    eq.push_back(e);
    nq.push_back(nm);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Counts busy cycles of one conversion, bounded
  task automatic len(input int e, input string nm);
    n = 0;
    for (int k = 0; k < 4000 && !(n > 0 && !busy); k++) begin
      @(posedge clk);
      if (busy) n++;
    end
    chk(nm, 10'(e), n[9:0]);
  endtask

  always @(posedge clk) begin
    if (rd_d) chk(nq.pop_front(), {2'b00, eq.pop_front()}, {2'b00, rdata});
    rd_d <= rd;
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    {rst_n, wr, rd, rd_d, gie, ack} = '0;
    {addr, wdata, trig, pl, ph, nv, r} = '0;
    void'($urandom(42));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 7; a++) rreg(4'(a), 8'h00, "reset");
    wreg(4'hC, 8'hFF);
    rreg(4'hC, 8'h00, "unmapped");
    $display("test 1 done");
    nv = 10'($urandom());
    wreg(4'h0, 8'hC0);
    len(50, "first_len");
    rreg(4'h0, 8'h90, "ctrl_a");
    rreg(4'h1, nv[7:0], "res_low");
    rreg(4'h2, {6'h00, nv[9:8]}, "res_high");
    wreg(4'h0, 8'h90);
    rreg(4'h0, 8'h80, "flag_clr");
    $display("test 2 done");
    gie <= 1'b1;
    nv = 10'($urandom());
    r = nv ^ 10'h200;
    wreg(4'h4, 8'h30);
    wreg(4'h0, 8'hCB);
    len(104, "div8_len");
    @(posedge clk);
    chk("irq", 10'h001, {9'h000, irq});
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    chk("irq_masked", 10'h000, {9'h000, irq});
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    gie <= 1'b1;
    repeat (2) @(posedge clk);
    chk("irq_acked", 10'h000, {9'h000, irq});
    rreg(4'h1, {r[1:0], 6'h00}, "la_low");
    rreg(4'h2, r[9:2], "la_high");
    $display("test 3 done");
    rreg(4'h1, {r[1:0], 6'h00}, "lock_low");
    nv = 10'($urandom());
    wreg(4'h0, 8'hC8);
    len(26, "lock_len");
    rreg(4'h2, r[9:2], "lock_high");
    rreg(4'h0, 8'h88, "lock_flag");
    $display("test 4 done");
    wreg(4'h4, 8'h00);
    wreg(4'h0, 8'h80);
    wreg(4'h3, 8'h01);
    trig <= 11'h001;
    repeat (4) @(posedge clk);
    chk("no_auto", 10'h000, {9'h000, busy});
    trig <= 11'h000;
    wreg(4'h0, 8'hA0);
    for (int c = 1; c < 12; c++) begin
      wreg(4'h3, 8'(c));
      trig <= 11'h001 << (c - 1);
      len(26, "trig_len");
      trig <= 11'h000;
    end
    $display("test 5 done");
    wreg(4'h3, 8'h01);
    trig <= 11'h002;
    wreg(4'h3, 8'h02);
    len(26, "switch_len");
    trig <= 11'h000;
    wreg(4'h3, 8'h00);
    repeat (4) @(posedge clk);
    chk("to_free", 10'h000, {9'h000, busy});
    wreg(4'h0, 8'hE0);
    repeat (40) @(posedge clk);
    chk("free_busy", 10'h001, {9'h000, busy});
    wreg(4'h0, 8'h00);
    repeat (2) @(posedge clk);
    chk("abort", 10'h000, {9'h000, busy});
    chk("core_off", 10'h000, {9'h000, cen});
    $display("test 6 done");
    wreg(4'h3, 8'hE0);
    wreg(4'h4, 8'h9F);
    repeat (2) @(posedge clk);
    chk("high_speed", 10'h001, {9'h000, hs});
    chk("channel", 10'h03F, {4'h0, chan});
    chk("comp_mux", 10'h001, {9'h000, cme});
    chk("ref_sel", 10'h002, {8'h00, rsel});
    $display("test 7 done");
    pl <= 8'($urandom());
    ph <= 6'($urandom());
    wreg(4'h5, 8'hFF);
    wreg(4'h6, 8'hFF);
    rreg(4'h5, 8'hF3, "dis_low");
    rreg(4'h6, 8'h3F, "dis_high");
    chk("pin_low", {2'b00, pl & 8'h0C}, {2'b00, opl});
    chk("pin_high", 10'h000, {4'h0, oph});
    repeat (2) @(posedge clk);
    $display("test 8 done");
    tally_and_finish();
  end
endmodule
